// ===== hdl/status_pkg.sv
package status_pkg;

  // datapath and exception vector widths
  localparam int XLEN    = 32;
  localparam int NUM_EXC = 6;

  // special register numbers
  localparam logic [7:0] SPR_STEP_Q = 8'h83;
  localparam logic [7:0] SPR_ALU    = 8'h84;
  localparam logic [7:0] SPR_FPS    = 8'ha2;

  // alu status field positions
  localparam int ALU_DF_BIT = 11;
  localparam int ALU_V_BIT  = 10;
  localparam int ALU_N_BIT  = 9;
  localparam int ALU_Z_BIT  = 8;
  localparam int ALU_C_BIT  = 7;

  // fp status field positions
  localparam int FPS_TRAP_LO   = 8;
  localparam int FPS_STICKY_LO = 0;

  // index of each exception inside a six bit vector
  localparam int EXC_DIVZERO  = 5;
  localparam int EXC_INEXACT  = 4;
  localparam int EXC_UNDERFLOW = 3;
  localparam int EXC_OVERFLOW = 2;
  localparam int EXC_RESERVED = 1;
  localparam int EXC_INVALID  = 0;

  // values after reset
  localparam logic [XLEN-1:0]    STEP_Q_RESET   = 32'h0000_0000;
  localparam logic [XLEN-1:0]    RDATA_RESET    = 32'h0000_0000;
  localparam logic [NUM_EXC-1:0] TRAP_RESET     = 6'h00;
  localparam logic [NUM_EXC-1:0] STICKY_RESET   = 6'h00;
  localparam logic               ALU_FLAG_RESET = 1'b0;

  // step operations
  typedef enum logic [1:0] {
    STEP_MULU,
    STEP_MUL,
    STEP_MULL,
    STEP_DIV
  } step_op_t;

endpackage

// ===== hdl/step_if.sv
`timescale 1ns/10ps
interface step_if #(parameter int W = 32);
  status_pkg::step_op_t op;
  logic [W-1:0]         first_source_operand;
  logic [W-1:0]         second_source_operand;
  logic [W-1:0]         q;
  logic                 df;
  logic [W-1:0]         result;
  logic [W-1:0]         q_next;
  logic                 df_next;
  logic                 flag_v;
  logic                 flag_c;
  logic                 flag_n;

  modport requester (output op, first_source_operand, second_source_operand, q, df,
                     input  result, q_next, df_next, flag_v, flag_c, flag_n);
  modport unit      (input  op, first_source_operand, second_source_operand, q, df,
                     output result, q_next, df_next, flag_v, flag_c, flag_n);
endinterface

// ===== hdl/step_unit.sv
`timescale 1ns/10ps
module step_unit #(parameter int W = 32) (
  step_if.unit sp
);
  logic [W-1:0] base;
  logic [W-1:0] addend;
  logic         cin;
  logic [W:0]   sum;
  logic         ovf;

  // one multiply or divide step, never a whole operation
  always_comb begin
    base   = sp.second_source_operand;
    addend = '0;
    cin    = 1'b0;
    case (sp.op)
      status_pkg::STEP_MULU, status_pkg::STEP_MUL: begin
        addend = sp.q[0] ? sp.first_source_operand : '0;
      end
      status_pkg::STEP_MULL: begin
        addend = sp.q[0] ? ~sp.first_source_operand : '0;
        cin    = sp.q[0];
      end
      status_pkg::STEP_DIV: begin
        base   = {sp.first_source_operand[W-2:0], sp.q[W-1]};
        addend = sp.df ? ~sp.second_source_operand : sp.second_source_operand;
        cin    = sp.df;
      end
      default: begin
        addend = '0;
      end
    endcase
    sum = {1'b0, base} + {1'b0, addend} + {{W{1'b0}}, cin};
    ovf = (base[W-1] == addend[W-1]) && (sum[W-1] != base[W-1]);
    sp.flag_v  = ovf;
    sp.flag_c  = sum[W];
    sp.flag_n  = sum[W-1];
    sp.df_next = sp.df;
    case (sp.op)
      status_pkg::STEP_MULU: begin
        sp.result = {sum[W], sum[W-1:1]};
        sp.q_next = {sum[0], sp.q[W-1:1]};
      end
      status_pkg::STEP_MUL, status_pkg::STEP_MULL: begin
        sp.result = {sum[W-1] ^ ovf, sum[W-1:1]};
        sp.q_next = {sum[0], sp.q[W-1:1]};
      end
      status_pkg::STEP_DIV: begin
        sp.result  = sum[W-1:0];
        sp.df_next = ~sum[W-1];
        sp.q_next  = {sp.q[W-2:0], ~sum[W-1]};
      end
      default: begin
        sp.result = sum[W-1:0];
        sp.q_next = sp.q;
      end
    endcase
  end
endmodule // step_unit

// ===== hdl/status_flags_top.sv
// Contract
// [RQ1] logical ops touch only negative, zero
// [RQ2] negative takes result msb
// [RQ3] zero set when result word zero
// [RQ4] masked exception sets its sticky bit
// [RQ5] trap sets applying trap bits regardless mask; trap bits load FP_COND only, so FP_RSV_OPERAND sets no trap bit
// [RQ6] trap clears non-applying trap bits
// [RQ7] hardware never clears sticky bits
// [RQ8] sticky update only masked, end of op
// [RQ9] trap bits change only on trap
// [RQ10] bit 13 divide by zero trap
// [RQ11] bit 12 inexact trap
// [RQ12] bits 11,10 underflow, overflow trap
// [RQ13] bits 9,8 reserved, invalid trap
// [RQ14] bit 5 divide by zero sticky
// [RQ15] bits 4,3,2 inexact, underflow, overflow sticky
// [RQ16] bits 1,0 reserved, invalid sticky
// [RQ17] only multiply and divide steps exist
// [RQ18] step register holds multiplier, quotient
// [RQ19] divide starts high dividend, ends remainder
// [RQ20] software uses unsigned step for unsigned
// [RQ21] mask zero traps, mask one suppresses
// [RQ22] fp status reserved bits read zero
`timescale 1ns/10ps
module status_flags_top #(
  parameter int XW = status_pkg::XLEN,
  parameter int NE = status_pkg::NUM_EXC
) (
  // clock and reset
  input  wire logic                 CLOCK,
  input  wire logic                 SYS_RST,
  // logical instruction result
  input  wire logic                 LOGIC_VALID,
  input  wire logic [XW-1:0]        LOGIC_RESULT,
  // multiply and divide step
  input  wire logic                 STEP_VALID,
  input  wire status_pkg::step_op_t STEP_OP,
  input  wire logic [XW-1:0]        STEP_FIRST_SOURCE_OPERAND,
  input  wire logic [XW-1:0]        STEP_SECOND_SOURCE_OPERAND,
  output logic      [XW-1:0]        STEP_RESULT,
  // fp exception report at end of execution
  input  wire logic                 FP_DONE,
  input  wire logic [NE-1:0]        FP_COND,
  input  wire logic                 FP_RSV_OPERAND,
  input  wire logic [NE-1:0]        FP_MASK,
  output logic                      FP_TRAP,
  // special register moves
  input  wire logic                 SPR_WE,
  input  wire logic                 SPR_RE,
  input  wire logic [7:0]           SPR_ADDR,
  input  wire logic [XW-1:0]        SPR_WDATA,
  output logic      [XW-1:0]        SPR_RDATA,
  // alu flags
  output logic                      ALU_NEG,
  output logic                      ALU_ZERO,
  output logic                      ALU_OVF,
  output logic                      ALU_CARRY,
  output logic                      ALU_DIVFLAG
);

  step_if #(.W(XW)) sp ();

  step_unit #(.W(XW)) u_step (
    .sp (sp.unit)
  );

  logic          n_q, n_d, z_q, z_d, v_q, v_d, c_q, c_d, df_q, df_d;
  logic [XW-1:0] q_q, q_d, res_q, res_d, rdata_q, rdata_d;
  logic [NE-1:0] trap_q, trap_d, sticky_q, sticky_d;
  logic          trap_out_q, trap_out_d;
  logic [NE-1:0] exc_vec, trap_vec;
  logic          trap_take;
  logic          wr_alu, wr_q, wr_fps;

  assign wr_alu = SPR_WE && (SPR_ADDR == status_pkg::SPR_ALU);
  assign wr_q   = SPR_WE && (SPR_ADDR == status_pkg::SPR_STEP_Q);
  assign wr_fps = SPR_WE && (SPR_ADDR == status_pkg::SPR_FPS);

  assign sp.op   = STEP_OP;
  assign sp.first_source_operand = STEP_FIRST_SOURCE_OPERAND;
  assign sp.second_source_operand = STEP_SECOND_SOURCE_OPERAND;
  assign sp.q    = q_q;
  assign sp.df   = df_q;

  // alu flags
  always_comb begin
    n_d   = n_q;
    z_d   = z_q;
    v_d   = v_q;
    c_d   = c_q;
    df_d  = df_q;
    res_d = res_q;
    if (wr_alu) begin
      n_d  = SPR_WDATA[status_pkg::ALU_N_BIT];
      z_d  = SPR_WDATA[status_pkg::ALU_Z_BIT];
      v_d  = SPR_WDATA[status_pkg::ALU_V_BIT];
      c_d  = SPR_WDATA[status_pkg::ALU_C_BIT];
      df_d = SPR_WDATA[status_pkg::ALU_DF_BIT];
    end
    if (STEP_VALID) begin
      n_d   = sp.flag_n;
      z_d   = (sp.result == '0);
      v_d   = sp.flag_v;
      c_d   = sp.flag_c;
      df_d  = sp.df_next;
      res_d = sp.result;
    end else if (LOGIC_VALID) begin
      // v and c keep their value [RQ1]
      n_d = LOGIC_RESULT[XW-1]; // [RQ2]
      z_d = (LOGIC_RESULT == '0); // [RQ3]
    end
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      n_q   <= status_pkg::ALU_FLAG_RESET;
      z_q   <= status_pkg::ALU_FLAG_RESET;
      v_q   <= status_pkg::ALU_FLAG_RESET;
      c_q   <= status_pkg::ALU_FLAG_RESET;
      df_q  <= status_pkg::ALU_FLAG_RESET;
      res_q <= status_pkg::STEP_Q_RESET;
    end else begin
      n_q   <= n_d;
      z_q   <= z_d;
      v_q   <= v_d;
      c_q   <= c_d;
      df_q  <= df_d;
      res_q <= res_d;
    end
  end

  // step register
  always_comb begin
    q_d = q_q;
    if (wr_q) begin
      q_d = SPR_WDATA; // [RQ19]
    end
    if (STEP_VALID) begin
      q_d = sp.q_next; // [RQ17] [RQ18] [RQ20]
    end
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      q_q <= status_pkg::STEP_Q_RESET;
    end else begin
      q_q <= q_d;
    end
  end

  // fp status
  always_comb begin
    exc_vec = FP_COND;
    exc_vec[status_pkg::EXC_RESERVED] = FP_COND[status_pkg::EXC_RESERVED] | FP_RSV_OPERAND; // [RQ16]
    trap_vec   = FP_COND; // [RQ10] [RQ11] [RQ12] [RQ13]
    trap_take  = FP_DONE && ((exc_vec & ~FP_MASK) != '0); // [RQ21]
    trap_out_d = trap_take;
    trap_d     = trap_q;
    sticky_d   = sticky_q;
    if (wr_fps) begin
      trap_d   = SPR_WDATA[status_pkg::FPS_TRAP_LO +: NE];
      sticky_d = SPR_WDATA[status_pkg::FPS_STICKY_LO +: NE]; // [RQ7]
    end
    if (trap_take) begin
      trap_d = trap_vec; // [RQ5] [RQ6] [RQ9]
    end
    if (FP_DONE) begin
      sticky_d = sticky_d | (exc_vec & FP_MASK); // [RQ4] [RQ8] [RQ14] [RQ15]
    end
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      trap_q     <= status_pkg::TRAP_RESET;
      sticky_q   <= status_pkg::STICKY_RESET;
      trap_out_q <= 1'b0;
    end else begin
      trap_q     <= trap_d;
      sticky_q   <= sticky_d;
      trap_out_q <= trap_out_d;
    end
  end

  // register reads
  always_comb begin
    rdata_d = rdata_q;
    if (SPR_RE) begin
      rdata_d = '0;
      case (SPR_ADDR)
        status_pkg::SPR_STEP_Q: begin
          rdata_d = q_q;
        end
        status_pkg::SPR_ALU: begin
          rdata_d[status_pkg::ALU_DF_BIT] = df_q;
          rdata_d[status_pkg::ALU_V_BIT]  = v_q;
          rdata_d[status_pkg::ALU_N_BIT]  = n_q;
          rdata_d[status_pkg::ALU_Z_BIT]  = z_q;
          rdata_d[status_pkg::ALU_C_BIT]  = c_q;
        end
        status_pkg::SPR_FPS: begin
          rdata_d[status_pkg::FPS_TRAP_LO +: NE]   = trap_q; // [RQ22]
          rdata_d[status_pkg::FPS_STICKY_LO +: NE] = sticky_q;
        end
        default: begin
          rdata_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rdata_q <= status_pkg::RDATA_RESET;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign ALU_NEG     = n_q;
  assign ALU_ZERO    = z_q;
  assign ALU_OVF     = v_q;
  assign ALU_CARRY   = c_q;
  assign ALU_DIVFLAG = df_q;
  assign STEP_RESULT = res_q;
  assign FP_TRAP     = trap_out_q;
  assign SPR_RDATA   = rdata_q;

  // checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  property p_logic_keeps_vc;
    (LOGIC_VALID && !STEP_VALID && !wr_alu) |=> $stable(ALU_OVF) && $stable(ALU_CARRY);
  endproperty
  a_logic_keeps_vc: assert property (p_logic_keeps_vc) else $error("logical op changed v or c"); // [RQ1]

  property p_logic_neg;
    (LOGIC_VALID && !STEP_VALID) |=> (ALU_NEG == $past(LOGIC_RESULT[XW-1]));
  endproperty
  a_logic_neg: assert property (p_logic_neg) else $error("negative flag wrong"); // [RQ2]

  property p_logic_zero;
    (LOGIC_VALID && !STEP_VALID) |=> (ALU_ZERO == ($past(LOGIC_RESULT) == '0));
  endproperty
  a_logic_zero: assert property (p_logic_zero) else $error("zero flag wrong"); // [RQ3]

  property p_sticky_set;
    (FP_DONE && ((exc_vec & FP_MASK) != '0)) |=> ((sticky_q & $past(exc_vec & FP_MASK)) == $past(exc_vec & FP_MASK));
  endproperty
  a_sticky_set: assert property (p_sticky_set) else $error("masked exception lost sticky"); // [RQ4]

  property p_sticky_hold;
    !wr_fps |=> ((sticky_q & $past(sticky_q)) == $past(sticky_q));
  endproperty
  a_sticky_hold: assert property (p_sticky_hold) else $error("sticky bit cleared by hardware"); // [RQ7]

  property p_trap_load;
    trap_take |=> (trap_q == $past(FP_COND)) && FP_TRAP;
  endproperty
  a_trap_load: assert property (p_trap_load) else $error("trap bits not loaded on trap"); // [RQ6]

  property p_trap_stable;
    (!trap_take && !wr_fps) |=> $stable(trap_q);
  endproperty
  a_trap_stable: assert property (p_trap_stable) else $error("trap bits moved without trap"); // [RQ9]

  property p_mask_suppress;
    (FP_DONE && ((exc_vec & ~FP_MASK) == '0)) |=> !FP_TRAP;
  endproperty
  a_mask_suppress: assert property (p_mask_suppress) else $error("masked exception trapped"); // [RQ21]

  property p_fps_reserved;
    (SPR_RE && SPR_ADDR == status_pkg::SPR_FPS) |=> (SPR_RDATA[31:14] == '0) && (SPR_RDATA[7:6] == '0);
  endproperty
  a_fps_reserved: assert property (p_fps_reserved) else $error("reserved bits read nonzero"); // [RQ22]

  property p_mul_shift;
    (STEP_VALID && STEP_OP != status_pkg::STEP_DIV) |=> (q_q[XW-2:0] == $past(q_q[XW-1:1]));
  endproperty
  a_mul_shift: assert property (p_mul_shift) else $error("multiplier not shifted"); // [RQ18]

  property p_div_shift;
    (STEP_VALID && STEP_OP == status_pkg::STEP_DIV) |=> (q_q[XW-1:1] == $past(q_q[XW-2:0]))
      && (q_q[0] == ALU_DIVFLAG);
  endproperty
  a_div_shift: assert property (p_div_shift) else $error("quotient bit not shifted in"); // [RQ19]

  c_trap:      cover property (trap_take ##1 FP_TRAP);
  c_sticky:    cover property (FP_DONE && !trap_take && ((exc_vec & FP_MASK) != '0));
  c_div_run:   cover property ((STEP_VALID && STEP_OP == status_pkg::STEP_DIV) [*3]);
  c_zero_flag: cover property (LOGIC_VALID && LOGIC_RESULT == '0 ##1 ALU_ZERO);

endmodule // status_flags_top

// ===== sim/status_flags_tb.sv
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin errors++; \
  $display("unexpected %s expected %h seen %h", nm, exp, got); end end
module status_flags_tb;
  logic                 CLOCK;
  logic                 SYS_RST;
  logic                 LOGIC_VALID;
  logic [31:0]          LOGIC_RESULT;
  logic                 STEP_VALID;
  status_pkg::step_op_t STEP_OP;
  logic [31:0]          STEP_FIRST_SOURCE_OPERAND;
  logic [31:0]          STEP_SECOND_SOURCE_OPERAND;
  logic [31:0]          STEP_RESULT;
  logic                 FP_DONE;
  logic [5:0]           FP_COND;
  logic                 FP_RSV_OPERAND;
  logic [5:0]           FP_MASK;
  logic                 FP_TRAP;
  logic                 SPR_WE;
  logic                 SPR_RE;
  logic [7:0]           SPR_ADDR;
  logic [31:0]          SPR_WDATA;
  logic [31:0]          SPR_RDATA;
  logic                 ALU_NEG;
  logic                 ALU_ZERO;
  logic                 ALU_OVF;
  logic                 ALU_CARRY;
  logic                 ALU_DIVFLAG;
  int                   errors;
  int                   compares;
  int                   cycles;
  logic [5:0]           m_trap;
  logic [5:0]           m_sticky;
  logic [31:0]          v;
  logic [31:0]          seed_v;

  status_flags_top i_status_flags_top (
    .CLOCK(CLOCK), .SYS_RST(SYS_RST), .LOGIC_VALID(LOGIC_VALID), .LOGIC_RESULT(LOGIC_RESULT),
    .STEP_VALID(STEP_VALID), .STEP_OP(STEP_OP), .STEP_FIRST_SOURCE_OPERAND(STEP_FIRST_SOURCE_OPERAND), .STEP_SECOND_SOURCE_OPERAND(STEP_SECOND_SOURCE_OPERAND),
    .STEP_RESULT(STEP_RESULT), .FP_DONE(FP_DONE), .FP_COND(FP_COND), .FP_RSV_OPERAND(FP_RSV_OPERAND),
    .FP_MASK(FP_MASK), .FP_TRAP(FP_TRAP), .SPR_WE(SPR_WE), .SPR_RE(SPR_RE), .SPR_ADDR(SPR_ADDR),
    .SPR_WDATA(SPR_WDATA), .SPR_RDATA(SPR_RDATA), .ALU_NEG(ALU_NEG), .ALU_ZERO(ALU_ZERO),
    .ALU_OVF(ALU_OVF), .ALU_CARRY(ALU_CARRY), .ALU_DIVFLAG(ALU_DIVFLAG)
  );

  initial begin
    CLOCK = 1'b0;
    forever #20 CLOCK = ~CLOCK;
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge CLOCK) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      report_and_stop();
    end
  end

  task automatic spr_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    SPR_WE    <= 1'b1;
    SPR_ADDR  <= a;
    SPR_WDATA <= d;
    @(posedge CLOCK);
    SPR_WE    <= 1'b0;
  endtask

  task automatic spr_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge CLOCK);
    SPR_RE   <= 1'b1;
    SPR_ADDR <= a;
    @(posedge CLOCK);
    SPR_RE   <= 1'b0;
    #1 d = SPR_RDATA;
  endtask

  task automatic logic_op(input logic [31:0] r);
    @(posedge CLOCK);
    LOGIC_VALID  <= 1'b1;
    LOGIC_RESULT <= r;
    @(posedge CLOCK);
    LOGIC_VALID  <= 1'b0;
    #1;
    `CHK("neg", r[31], ALU_NEG)
    `CHK("zero", (r == 32'h0000_0000), ALU_ZERO)
    `CHK("ovf carry", 2'h3, {ALU_OVF, ALU_CARRY})
  endtask

  task automatic fp_op(input logic [5:0] c, input logic rs, input logic [5:0] m);
    logic [5:0] e;
    logic       t;
    e = c | {4'h0, rs, 1'b0};
    t = |(e & ~m);
    @(posedge CLOCK);
    FP_DONE        <= 1'b1;
    FP_COND        <= c;
    FP_RSV_OPERAND <= rs;
    FP_MASK        <= m;
    @(posedge CLOCK);
    FP_DONE        <= 1'b0;
    #1;
    `CHK("trap", t, FP_TRAP)
    if (t) m_trap = c;
    m_sticky = m_sticky | (e & m);
    @(posedge CLOCK);
    #1;
    `CHK("trap pulse", 1'b0, FP_TRAP)
    spr_rd(8'ha2, v);
    `CHK("fps", {18'h0, m_trap, 2'h0, m_sticky}, v)
  endtask

  task automatic step(input status_pkg::step_op_t op, input logic [31:0] a, input logic [31:0] b);
    @(posedge CLOCK);
    STEP_VALID <= 1'b1;
    STEP_OP    <= op;
    STEP_FIRST_SOURCE_OPERAND  <= a;
    STEP_SECOND_SOURCE_OPERAND  <= b;
    @(posedge CLOCK);
    STEP_VALID <= 1'b0;
    #1;
  endtask

  task automatic mul_run(input bit sgn, input logic [31:0] a, input logic [31:0] b);
    logic [63:0] p;
    logic [31:0] acc;
    p   = sgn ? 64'($signed({{32{a[31]}}, a}) * $signed({{32{b[31]}}, b})) : {32'h0, a} * {32'h0, b};
    acc = 32'h0000_0000;
    spr_wr(8'h83, b);
    for (int i = 0; i < 32; i++) begin
      step(sgn ? ((i == 31) ? status_pkg::STEP_MULL : status_pkg::STEP_MUL) : status_pkg::STEP_MULU, a, acc);
      acc = STEP_RESULT;
    end
    `CHK("product high", p[63:32], acc)
    spr_rd(8'h83, v);
    `CHK("product low", p[31:0], v)
  endtask

  initial begin
    errors = 0; compares = 0; cycles = 0; m_trap = 6'h00; m_sticky = 6'h00;
    SYS_RST = 1'b1; LOGIC_VALID = 1'b0; LOGIC_RESULT = 32'h0; STEP_VALID = 1'b0;
    STEP_OP = status_pkg::STEP_MULU; STEP_FIRST_SOURCE_OPERAND = 32'h0; STEP_SECOND_SOURCE_OPERAND = 32'h0; FP_DONE = 1'b0;
    FP_COND = 6'h00; FP_RSV_OPERAND = 1'b0; FP_MASK = 6'h3f; SPR_WE = 1'b0; SPR_RE = 1'b0;
    SPR_ADDR = 8'h00; SPR_WDATA = 32'h0;
    seed_v = $urandom(32'h5d5c);
    repeat (8) @(posedge CLOCK);
    SYS_RST <= 1'b0;
    // reset values
    spr_rd(8'h83, v);
    `CHK("step reg reset", 32'h0, v)
    spr_rd(8'ha2, v);
    `CHK("fps reset", 32'h0, v)
    // unmapped place
    spr_wr(8'h55, 32'hffff_ffff);
    spr_rd(8'h55, v);
    `CHK("unmapped", 32'h0, v)
    // reserved fps bits
    spr_wr(8'ha2, 32'hffff_ffff);
    spr_rd(8'ha2, v);
    `CHK("fps reserved", 32'h0000_3f3f, v)
    spr_wr(8'ha2, 32'h0);
    // logical ops keep overflow and carry
    spr_wr(8'h84, 32'h0000_0480);
    logic_op(32'h0000_0000);
    logic_op(32'h8000_0000);
    logic_op(32'h0000_0000);
    for (int i = 0; i < 20; i++) logic_op($urandom);
    // fp exceptions
    fp_op(6'h10, 1'b0, 6'h00);
    fp_op(6'h3f, 1'b0, 6'h3f);
    fp_op(6'h00, 1'b1, 6'h3d);
    fp_op(6'h00, 1'b1, 6'h3f);
    fp_op(6'h21, 1'b0, 6'h1e);
    for (int i = 0; i < 40; i++) fp_op(6'($urandom), 1'($urandom), 6'($urandom | $urandom));
    spr_wr(8'ha2, 32'h0000_0000);
    m_trap = 6'h00;
    m_sticky = 6'h00;
    fp_op(6'h04, 1'b0, 6'h3b);
    // multiply sequences
    mul_run(1'b0, 32'hffff_ffff, 32'hffff_ffff);
    mul_run(1'b1, 32'h8000_0000, 32'h7fff_ffff);
    for (int i = 0; i < 4; i++) begin
      mul_run(1'b0, $urandom, $urandom);
      mul_run(1'b1, $urandom, $urandom);
    end
    // one divide step with the divide flag clear
    spr_wr(8'h84, 32'h0000_0000);
    spr_wr(8'h83, 32'h9234_5679);
    step(status_pkg::STEP_DIV, 32'h4000_0003, 32'h1000_0000);
    `CHK("div sum", 32'h9000_0007, STEP_RESULT)
    spr_rd(8'h83, v);
    `CHK("div q", 32'h2468_acf2, v)
    `CHK("div flag", 1'b0, ALU_DIVFLAG)
    spr_rd(8'h84, v);
    `CHK("alu status after div", 32'h0000_0200, v)
    report_and_stop();
  end
endmodule // status_flags_tb
